// ### rscl_board.sv
// Purpose: Board model of the strap pull resistors on the shared pins.
// Assumes: External pulls are strong enough to set every strap level.
// Notes: A pin the latch drives shows the latch value, else its pull.
`timescale 1ns/1ps
module rscl_board (
  // Pull levels fitted on the board
  input wire rscl_pkg::rscl_strap_type pull_i,
  // Latch pin drivers
  input wire rscl_pkg::rscl_strap_type drive_i,
  input wire rscl_pkg::rscl_strap_type drive_en_i,
  // Resolved pin levels
  output rscl_pkg::rscl_strap_type level_o
);
  import rscl_pkg::*;
  // A driven pin overrides its pull, so only a released pin shows its pull
  assign level_o = (drive_en_i & drive_i) | (~drive_en_i & pull_i);
endmodule

// ### rscl_cfg_mem.sv
// Purpose: Small register array holding the seeded control words.
// Assumes: One write port, one read port with registered data.
// Notes: Contents are loaded by the latch, then by software.
`timescale 1ns/1ps
module rscl_cfg_mem #(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// ### rscl_latch.sv
// Purpose: Samples strap pins at reset release; seeds control words.
// Assumes: Straps synchronous to clk_i; register port of the core.
// Notes: Shared pins become outputs only after the sample.
//
// Contract
// - Sample all straps once at reset release.
// - Address straps give low bits, default 1.
// - Address bits 4:3 are always zero.
// - Address 0 broadcast unless strap/bit 9 disables.
// - Capture interface mode field at release.
// - Isolate strap seeds control bit 10.
// - Speed strap seeds bit 13 and advertisement.
// - Duplex strap seeds control bit 8.
// - Autoneg strap seeds control bit 12.
// - Low pin-chain test strap enables test mode.
// - Shared pins input during reset, output after.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "rscl_regs.svh"
module rscl_latch (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Strap pins, shared with outputs
  input wire rscl_pkg::rscl_strap_type strap_i,
  input wire logic bcast_disable_strap_i,
  input wire logic test_strap_n_i,
  input wire rscl_pkg::rscl_strap_type func_out_i,
  output rscl_pkg::rscl_strap_type strap_o,
  output rscl_pkg::rscl_strap_type strap_oe_o,
  // Register port
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Configuration outputs
  output logic [4:0] mgmt_addr_o,
  output logic [2:0] if_mode_o,
  output logic bcast_en_o,
  output logic test_mode_o,
  output logic cfg_valid_o
);
  import rscl_pkg::*;

  rscl_state_type state;
  rscl_state_type next_state;
  rscl_strap_type lat;
  logic bcast_off_lat;
  logic test_n_lat;
  logic bcast_sw;
  logic rd_q;
  logic [1:0] rd_sel;
  logic [15:0] mem_rdata;

  function automatic logic [15:0] ctrl_seed(input rscl_strap_type s);
    logic [15:0] v;
    v = `RSCL_CTRL_RST_VAL;
    v[`RSCL_CTRL_SPEED_BIT] = s.speed;
    v[`RSCL_CTRL_ANEG_BIT] = s.aneg;
    v[`RSCL_CTRL_ISO_BIT] = s.iso;
    v[`RSCL_CTRL_DUPLEX_BIT] = s.duplex;
    return v;
  endfunction

  function automatic logic [15:0] adv_seed(input logic spd);
    return spd ? (`RSCL_ADV_RST_VAL | `RSCL_ADV_100_MASK | `RSCL_ADV_10_MASK)
               : (`RSCL_ADV_RST_VAL | `RSCL_ADV_10_MASK);
  endfunction

  // Decode
  wire sampling = (state == RSCL_ST_SAMPLE);
  wire running = (state == RSCL_ST_RUN);
  wire hit_ctrl = (addr_i == `RSCL_OFS_CTRL);
  wire hit_adv = (addr_i == `RSCL_OFS_ADV);
  wire hit_misc = (addr_i == `RSCL_OFS_MISC);
  wire hit_strap = (addr_i == `RSCL_OFS_STRAP);
  wire sw_we = wr_i && running && (hit_ctrl || hit_adv);
  wire [1:0] sw_waddr = hit_adv ? 2'h1 : 2'h0;
  // Seeding uses slot 0 on the sample cycle, slot 1 the cycle after
  wire seed_ctrl = sampling;
  wire seed_adv = (state == RSCL_ST_RUN) && !cfg_valid_o;
  wire mem_we = seed_ctrl || seed_adv || sw_we;
  wire [1:0] mem_waddr = seed_ctrl ? 2'h0 : (seed_adv ? 2'h1 : sw_waddr);
  wire [15:0] mem_wdata = seed_ctrl ? ctrl_seed(strap_i) :
                          (seed_adv ? adv_seed(lat.speed) : wdata_i);
  wire [1:0] mem_raddr = hit_adv ? 2'h1 : 2'h0;
  wire [15:0] misc_word = {6'h00, bcast_sw, 9'h000};
  wire [15:0] strap_word = {3'h0, bcast_off_lat, test_n_lat, lat.addr,
                            lat.mode, lat.iso, lat.speed, lat.duplex,
                            lat.aneg, 1'b0};
  wire [15:0] side_word = (rd_sel == 2'h2) ? misc_word :
                          (rd_sel == 2'h3) ? strap_word : 16'h0000;

  always_comb begin
    case (state)
      RSCL_ST_RESET: next_state = RSCL_ST_SAMPLE;
      RSCL_ST_SAMPLE: next_state = RSCL_ST_RUN;
      RSCL_ST_RUN: next_state = RSCL_ST_RUN;
      default: next_state = RSCL_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= RSCL_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // One sample in the SAMPLE state, the second cycle after reset release
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lat <= rscl_strap_type'(`RSCL_STRAP_DEFAULT);
      bcast_off_lat <= 1'b0;
      test_n_lat <= 1'b1;
    end else if (sampling) begin
      lat <= strap_i;
      bcast_off_lat <= bcast_disable_strap_i;
      test_n_lat <= test_strap_n_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bcast_sw <= 1'b0;
    end else if (wr_i && running && hit_misc) begin
      bcast_sw <= wdata_i[`RSCL_MISC_BCAST_BIT];
    end
  end

  // Outputs of the configuration
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mgmt_addr_o <= {`RSCL_ADDR_HI, `RSCL_ADDR_DEFAULT};
      if_mode_o <= 3'h0;
      bcast_en_o <= 1'b1;
      test_mode_o <= 1'b0;
      cfg_valid_o <= 1'b0;
    end else begin
      mgmt_addr_o <= {`RSCL_ADDR_HI, lat.addr};
      if_mode_o <= lat.mode;
      bcast_en_o <= !(bcast_off_lat || bcast_sw);
      test_mode_o <= !test_n_lat;
      cfg_valid_o <= running;
    end
  end

  // Pins stay inputs until the sample is taken
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      strap_o <= '0;
      strap_oe_o <= '0;
    end else begin
      strap_o <= func_out_i;
      strap_oe_o <= running ? '1 : '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_q <= 1'b0;
      rd_sel <= 2'h0;
    end else begin
      // Unmapped reads leave rd_q low and so read as zero
      rd_q <= rd_i && (hit_ctrl || hit_adv || hit_misc || hit_strap);
      rd_sel <= hit_ctrl ? 2'h0 : hit_adv ? 2'h1 : hit_misc ? 2'h2 : 2'h3;
    end
  end

  rscl_cfg_mem #(
    .DEPTH(4),
    .AW(2)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // Read data muxed combinationally from registered sources
  logic [15:0] read_word;
  assign read_word = (rd_sel[1] == 1'b0) ? mem_rdata : side_word;
  // Memory data already leave a register, so only a select follows it;
  // this keeps the answer in the cycle right after the read strobe
  assign rdata_o = rd_q ? read_word : 16'h0000;

  // Assertions
  AST_ADDR_HI: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mgmt_addr_o[4:3] == 2'h0)
    else $error("upper address bits not zero");
  AST_SAMPLE_ONCE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    running |=> $stable(lat) && $stable(test_n_lat))
    else $error("strap latch changed after sample");
  AST_ADDR_SRC: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sampling |-> ##2 mgmt_addr_o[2:0] == $past(strap_i.addr, 2))
    else $error("address not taken from straps");
  AST_MODE_SRC: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sampling |-> ##2 if_mode_o == $past(strap_i.mode, 2))
    else $error("mode not taken from straps");
  AST_BCAST: assert property (@(posedge clk_i) disable iff (!rstn_i)
    running && $past(running) |=> bcast_en_o ==
      !($past(bcast_off_lat) || $past(bcast_sw)))
    else $error("broadcast enable wrong");
  AST_TEST: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sampling && !test_strap_n_i |-> ##2 test_mode_o)
    else $error("test mode not entered");
  AST_ISO_IN: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !running |=> strap_oe_o == '0)
    else $error("pin driven before sample");
  AST_SEED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sampling |-> mem_we && mem_waddr == 2'h0 &&
      mem_wdata[`RSCL_CTRL_ISO_BIT] == strap_i.iso &&
      mem_wdata[`RSCL_CTRL_DUPLEX_BIT] == strap_i.duplex &&
      mem_wdata[`RSCL_CTRL_ANEG_BIT] == strap_i.aneg)
    else $error("control word seed wrong");
  AST_SPEED_SEED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    sampling |-> mem_wdata[`RSCL_CTRL_SPEED_BIT] == strap_i.speed)
    else $error("speed select seed wrong");

  // Advertisement seeding is the step in the cycle right after the sample
  sequence seq_seed_then_run;
    sampling ##1 running;
  endsequence

  AST_ADV_SEED: assert property (@(posedge clk_i) disable iff (!rstn_i)
    seq_seed_then_run |-> mem_we && mem_waddr == 2'h1 &&
      ((mem_wdata & `RSCL_ADV_10_MASK) == `RSCL_ADV_10_MASK) &&
      ((mem_wdata & `RSCL_ADV_100_MASK) ==
        (lat.speed ? `RSCL_ADV_100_MASK : 16'h0000)))
    else $error("advertisement seed wrong");

  // Pins drive only once the configuration is complete
  AST_OE_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
    running && cfg_valid_o |-> strap_oe_o == '1)
    else $error("pin not driven after sample");
  AST_FUNC_OUT: assert property (@(posedge clk_i) disable iff (!rstn_i)
    running |=> strap_o == $past(func_out_i))
    else $error("pin output does not follow function");

  // Latched outputs hold once the seeded values have settled
  AST_CFG_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
    running && $past(running, 2) |->
      $stable(mgmt_addr_o) && $stable(if_mode_o) &&
      $stable(test_mode_o))
    else $error("configuration changed after sample");

  // A read of the strap status returns what was latched
  sequence seq_rd_strap;
    rd_i && hit_strap;
  endsequence

  AST_RD_STRAP: assert property (@(posedge clk_i) disable iff (!rstn_i)
    seq_rd_strap |=> rdata_o[10:1] == $past(lat) &&
      rdata_o[12] == $past(bcast_off_lat) &&
      rdata_o[11] == $past(test_n_lat))
    else $error("strap status read wrong");
  AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside answer cycle");
endmodule

// ### rscl_pkg.sv
// Purpose: Types for the strap configuration latch.
// Assumes: Nothing beyond the header.
// Notes: Strap vector bit layout is fixed by rscl_strap_type.
package rscl_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [2:0] mode;
    logic iso;
    logic speed;
    logic duplex;
    logic aneg;
  } rscl_strap_type;

  typedef enum logic [2:0] {
    RSCL_ST_RESET = 3'h1,
    RSCL_ST_SAMPLE = 3'h2,
    RSCL_ST_RUN = 3'h4
  } rscl_state_type;
endpackage

// ### rscl_regs.svh
// Purpose: Named constants for the strap configuration latch.
// Assumes: Included by the strap latch files only.
// Notes: Bit positions refer to the basic control register (0h), except the broadcast bit of the misc register (16h).
`ifndef RSCL_REGS_SVH
`define RSCL_REGS_SVH

`define RSCL_CTRL_SPEED_BIT 13
`define RSCL_CTRL_ANEG_BIT 12
`define RSCL_CTRL_ISO_BIT 10
`define RSCL_CTRL_DUPLEX_BIT 8
`define RSCL_CTRL_RST_VAL 16'h0000
`define RSCL_ADV_RST_VAL 16'h0001
`define RSCL_ADV_100_MASK 16'h0380
`define RSCL_ADV_10_MASK 16'h0060
`define RSCL_MISC_BCAST_BIT 9
`define RSCL_ADDR_HI 2'h0
`define RSCL_ADDR_DEFAULT 3'h1
`define RSCL_STRAP_DEFAULT 10'h087

`define RSCL_OFS_CTRL 5'h00
`define RSCL_OFS_ADV 5'h04
`define RSCL_OFS_MISC 5'h16
`define RSCL_OFS_STRAP 5'h1E

`endif

// ### test_reset_strap_config_latch.sv
// Purpose: Self-checking bench for the strap configuration latch.
// Assumes: Straps come from board pulls; pins are driven after sampling.
// Notes: Read data is taken in the one cycle where it stands.
`timescale 1ns/1ps
`include "rscl_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module test_reset_strap_config_latch;
  import rscl_pkg::*;
  logic clk_i = 0;
  logic rstn_i = 0;
  rscl_strap_type pull = '0;
  rscl_strap_type func_out_i = '0;
  rscl_strap_type strap_i, strap_o, strap_oe_o;
  logic bc = 0;
  logic tn = 1;
  logic [4:0] addr_i = '0;
  logic [15:0] wdata_i = '0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic [15:0] rdata_o, rv, ctrl, adv;
  logic [4:0] mgmt_addr_o;
  logic [2:0] if_mode_o;
  logic bcast_en_o, test_mode_o, cfg_valid_o;
  int n_mismatch = 0;
  int checked = 0;

  always #2 clk_i = ~clk_i;

  rscl_board u_board (.pull_i(pull), .drive_i(strap_o),
    .drive_en_i(strap_oe_o), .level_o(strap_i));
  rscl_latch u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .strap_i(strap_i),
    .bcast_disable_strap_i(bc), .test_strap_n_i(tn),
    .func_out_i(func_out_i), .strap_o(strap_o), .strap_oe_o(strap_oe_o),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .mgmt_addr_o(mgmt_addr_o), .if_mode_o(if_mode_o),
    .bcast_en_o(bcast_en_o), .test_mode_o(test_mode_o),
    .cfg_valid_o(cfg_valid_o));

  task stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [4:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask

  task run_cfg(input rscl_strap_type s, input logic b, input logic t);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    pull <= s;
    bc <= b;
    tn <= t;
    func_out_i <= s;
    repeat (4) @(posedge clk_i);
    `CHK(strap_oe_o, 10'h000)
    rstn_i <= 1'b1;
    for (int k = 0; k < 12 && cfg_valid_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    ctrl = 16'h0000;
    ctrl[`RSCL_CTRL_SPEED_BIT] = s.speed;
    ctrl[`RSCL_CTRL_ANEG_BIT] = s.aneg;
    ctrl[`RSCL_CTRL_ISO_BIT] = s.iso;
    ctrl[`RSCL_CTRL_DUPLEX_BIT] = s.duplex;
    adv = `RSCL_ADV_RST_VAL | `RSCL_ADV_10_MASK;
    adv = adv | (s.speed ? `RSCL_ADV_100_MASK : 16'h0000);
    `CHK(mgmt_addr_o, {2'h0, s.addr})
    `CHK(if_mode_o, s.mode)
    `CHK(bcast_en_o, ~b)
    `CHK(test_mode_o, ~t)
    `CHK(strap_oe_o, 10'h3FF)
    rd(`RSCL_OFS_CTRL);
    `CHK(rv, ctrl)
    wr(5'h05, 16'hFFFF);
    rd(`RSCL_OFS_ADV);
    `CHK(rv, adv)
    // Pins now carry their output function; nothing may be sampled again
    @(posedge clk_i);
    func_out_i <= ~s;
    bc <= ~b;
    tn <= ~t;
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(strap_o, ~s)
    `CHK(mgmt_addr_o, {2'h0, s.addr})
    `CHK(if_mode_o, s.mode)
    `CHK(test_mode_o, ~t)
    wr(`RSCL_OFS_MISC, 16'h0200);
    wr(`RSCL_OFS_CTRL, ctrl ^ 16'h3500);
    rd(`RSCL_OFS_CTRL);
    `CHK(rv, ctrl ^ 16'h3500)
    `CHK(bcast_en_o, 1'b0)
    rd(`RSCL_OFS_MISC);
    `CHK(rv, 16'h0200)
    rd(`RSCL_OFS_STRAP);
    `CHK(rv, {3'h0, b, t, s, 1'b0})
    rd(5'h05);
    `CHK(rv, 16'h0000)
  endtask

  initial begin
    run_cfg(10'h087, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
      run_cfg('{addr: i[2:0], mode: ~i[2:0], iso: i[0], speed: i[1],
        duplex: i[2], aneg: ~i[0]}, i[0] ^ i[1], ~i[2]);
    stop_test();
  end

  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
endmodule
